/* File: tb/ecf_host.sv */
`timescale 1ns/1ps
module ecf_host (
  input wire sys_clk,
  output logic [7:0] rxData,
  output logic rxValid,
  input wire rxReady,
  input wire [7:0] txData,
  input wire txValid,
  output logic txReady,
  input wire slow
);
  logic [7:0] sendQ[$];
  logic [7:0] gotQ[$];
  initial
  begin
    rxData = 8'hA5;
    rxValid = 1'b0;
    txReady = 1'b1;
  end
  always @(posedge sys_clk)
  begin
    if (rxValid && rxReady)
      void'(sendQ.pop_front());
    if (txValid && txReady)
      gotQ.push_back(txData);
    #1;
    rxValid = (sendQ.size() > 0);
    // Idle byte flips so a stale value never looks fresh
    rxData = rxValid ? sendQ[0] : ~rxData;
    txReady = !slow || !txReady;
  end
endmodule // ecf_host

/* File: tb/ecf_monitor.sv */
`timescale 1ns/1ps
module ecf_monitor (
  input wire sys_clk,
  input wire rst_n,
  input wire [7:0] rxData,
  input wire rxValid,
  input wire rxReady,
  input wire [7:0] txData,
  input wire txValid,
  input wire txReady,
  input wire frameDropped
);
  logic [3:0] idx_q;
  logic [7:0] sum_q;
  // Reply position wraps every 16 bytes
  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      idx_q <= 4'h0;
      sum_q <= 8'h00;
    end
    else if (txValid && txReady)
    begin
      idx_q <= idx_q + 4'h1;
      sum_q <= (idx_q == 4'hF) ? 8'h00 : sum_q ^ txData;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  tx_hold_a: assert property (txValid && !txReady
    |=> txValid && $stable(txData)) else $error("stalled byte moved");
  drop_pulse_a: assert property (frameDropped
    |=> !frameDropped) else $error("drop pulse too long");
  reply_start_a: assert property ($fell(rxReady) && !txValid
    |-> ##1 txValid && txData == 8'h15) else $error("bad reply start");
  len_low_a: assert property (txValid && idx_q == 4'h1
    |-> txData == 8'h0D) else $error("bad length low");
  len_high_a: assert property (txValid && idx_q == 4'h2
    |-> txData == 8'h00) else $error("bad length high");
  sub_code_a: assert property (txValid && idx_q == 4'h3
    |-> txData == 8'h82) else $error("bad reply code");
  data_count_a: assert property (txValid && idx_q == 4'h4
    |-> txData == 8'h0A) else $error("bad data count");
  check_xor_a: assert property (txValid && idx_q == 4'hF
    |-> txData == sum_q) else $error("bad check byte");
endmodule // ecf_monitor
bind ecf_framer ecf_monitor ecf_monitor_i (.sys_clk(sys_clk), .rst_n(rst_n),
  .rxData(rxData), .rxValid(rxValid), .rxReady(rxReady), .txData(txData),
  .txValid(txValid), .txReady(txReady), .frameDropped(frameDropped));

/* File: tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
  // Arbitrary serial value
  localparam [79:0] SER = 80'h3C1E0F8796C3E1F0785A;
  localparam [39:0] HDR = 40'h150D00820A;
  typedef struct {logic [63:0] b; int n; int rep; int drp;} ecf_row_t;
  logic sys_clk, rst_n, slow, rxValid, rxReady, txValid, txReady;
  logic frameDropped;
  logic [7:0] rxData, txData;
  logic [7:0] expR[16];
  int n_fail, n_checks, drops, cyc;
  ecf_row_t rows[8] = '{'{64'h6B030002006A, 6, 1, 0},
    '{64'h6B030002006B, 6, 0, 1},
    '{64'h6B040002001122, 7, 0, 1},
    '{64'h6B030003006B, 6, 0, 0},
    '{64'h62010063, 4, 0, 0},
    '{64'h6B040002015539, 7, 0, 0},
    '{64'h6B010055, 4, 0, 1},
    '{64'h6B0000, 3, 0, 1}};
  ecf_framer #(.SERIAL_NUMBER(SER)) ecf_framer_i (.sys_clk(sys_clk),
    .rst_n(rst_n), .rxData(rxData), .rxValid(rxValid), .rxReady(rxReady),
    .txData(txData), .txValid(txValid), .txReady(txReady),
    .frameDropped(frameDropped));
  ecf_host ecf_host_i (.sys_clk(sys_clk), .rxData(rxData),
    .rxValid(rxValid), .rxReady(rxReady), .txData(txData),
    .txValid(txValid), .txReady(txReady), .slow(slow));
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    cyc++;
    if (frameDropped === 1'b1)
      drops++;
    if (cyc == 4000)
    begin
      n_fail++;
      close_out();
    end
  end
  task automatic close_out();
    if (n_fail == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic send(logic [63:0] b, int n);
    for (int i = n - 1; i >= 0; i--)
      ecf_host_i.sendQ.push_back(b[8*i +: 8]);
  endtask
  // Waits out frame and reply; the cycle limit catches a hang
  task automatic settle(int reps, int drp);
    repeat (3) @(posedge sys_clk);
    #2;
    while (ecf_host_i.sendQ.size() > 0 || !rxReady || txValid)
    begin
      @(posedge sys_clk);
      #2;
    end
    repeat (2) @(posedge sys_clk);
    check("drops", 8'(drops), 8'(drp));
    check("reply size", 8'(ecf_host_i.gotQ.size()), 8'(16*reps));
    foreach (ecf_host_i.gotQ[i])
      check("reply byte", ecf_host_i.gotQ[i], expR[i%16]);
    ecf_host_i.gotQ.delete();
    drops = 0;
  endtask
  initial
  begin
    rst_n = 1'b0;
    slow = 1'b0;
    expR[15] = 8'h00;
    for (int i = 0; i < 15; i++)
    begin
      expR[i] = (i < 5) ? HDR[39-8*i -: 8] : SER[79-8*(i-5) -: 8];
      expR[15] ^= expR[i];
    end
    repeat (3) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    // First byte only in the cycle after reset is seen released
    @(posedge sys_clk);
    foreach (rows[r])
    begin
      send(rows[r].b, rows[r].n);
      settle(rows[r].rep, rows[r].drp);
    end
    // Back to back reads against a stalling receiver
    slow = 1'b1;
    send(rows[0].b, 6);
    send(rows[0].b, 6);
    settle(2, 0);
    // Reset lands in the middle of a reply
    send(rows[0].b, 6);
    repeat (9) @(posedge sys_clk);
    #1 rst_n = 1'b0;
    @(posedge sys_clk);
    #1 rst_n = 1'b1;
    check("ready after reset", {7'h00, rxReady}, 8'h01);
    check("valid after reset", {7'h00, txValid}, 8'h00);
    check("drop after reset", {7'h00, frameDropped}, 8'h00);
    @(posedge sys_clk);
    ecf_host_i.gotQ.delete();
    send(rows[0].b, 6);
    settle(1, 0);
    close_out();
  end
endmodule // testbench

/* File: verilog/ecf_consts.vh */
`ifndef ECF_CONSTS_VH
`define ECF_CONSTS_VH

`define ECF_TYPE_ESCAPE 8'h6B
`define ECF_TYPE_REPLY 8'h15
`define ECF_SUB_SERIAL 8'h02
`define ECF_REPLY_SERIAL 8'h82
`define ECF_SERIAL_COUNT 8'h0A
`define ECF_REPLY_LEN_LOW 8'h0D
`define ECF_REPLY_LEN_HIGH 8'h00
`define ECF_LEN_OVERHEAD 16'h0003
`define ECF_LEN_MIN 16'h0003
`define ECF_SKIP_AFTER_COUNT 16'h0002
`define ECF_REPLY_FIRST_SERIAL 4'h5
`define ECF_REPLY_LAST 4'hF
// Arbitrary value, replace per unit
`define ECF_SERIAL_DEFAULT 80'h0123456789ABCDEF5A5A

`endif

/* File: verilog/ecf_framer.v */
`timescale 1ns/1ps
`include "ecf_consts.vh"
module ecf_framer #(
  parameter [79:0] SERIAL_NUMBER = `ECF_SERIAL_DEFAULT
) (
  input wire sys_clk,
  input wire rst_n,
  input wire [7:0] rxData,
  input wire rxValid,
  output wire rxReady,
  output wire [7:0] txData,
  output wire txValid,
  input wire txReady,
  output reg frameDropped
);
  localparam [8:0] ST_TYPE = 9'h001;
  localparam [8:0] ST_LENL = 9'h002;
  localparam [8:0] ST_LENH = 9'h004;
  localparam [8:0] ST_CODE = 9'h008;
  localparam [8:0] ST_CNT = 9'h010;
  localparam [8:0] ST_DATA = 9'h020;
  localparam [8:0] ST_CHK = 9'h040;
  localparam [8:0] ST_SKIP = 9'h080;
  localparam [8:0] ST_RESP = 9'h100;

  reg [8:0] state_q;
  reg [8:0] state_d;
  reg [15:0] len_q;
  reg [15:0] len_d;
  reg [15:0] rem_q;
  reg [15:0] rem_d;
  reg [7:0] cnt_q;
  reg [7:0] cnt_d;
  reg [7:0] code_q;
  reg [7:0] code_d;
  reg [7:0] xor_q;
  reg [7:0] xor_d;
  reg typeOk_q;
  reg typeOk_d;
  reg [3:0] idx_q;
  reg [3:0] idx_d;
  reg [7:0] txXor_q;
  reg [7:0] txXor_d;
  reg drop_d;
  wire rxTake;
  wire pushReady;
  wire pushValid;
  wire [7:0] pushData;
  wire [15:0] lenNow;

  // Length covers sub-code, count, data and check byte
  function [15:0] lengthForCount;
    input [7:0] n;
    begin
      lengthForCount = {8'h00, n} + `ECF_LEN_OVERHEAD;
    end
  endfunction

  function [7:0] replyByte;
    input [3:0] idx;
    input [7:0] check;
    input [79:0] serial;
    reg [3:0] pos;
    begin
      pos = idx - `ECF_REPLY_FIRST_SERIAL;
      replyByte = 8'h00;
      case (idx)
        4'h0: replyByte = `ECF_TYPE_REPLY;
        4'h1: replyByte = `ECF_REPLY_LEN_LOW;
        4'h2: replyByte = `ECF_REPLY_LEN_HIGH;
        4'h3: replyByte = `ECF_REPLY_SERIAL;
        4'h4: replyByte = `ECF_SERIAL_COUNT;
        `ECF_REPLY_LAST: replyByte = check;
        default: replyByte = serial[79 - 8 * pos -: 8];
      endcase
    end
  endfunction

  // Input is held off while answering; the host simply waits
  assign rxReady = (state_q != ST_RESP);
  assign rxTake = rxValid & rxReady;
  assign pushValid = (state_q == ST_RESP);
  assign pushData = replyByte(idx_q, txXor_q, SERIAL_NUMBER);
  assign lenNow = {rxData, len_q[7:0]};

  always @*
  begin
    state_d = state_q;
    len_d = len_q;
    rem_d = rem_q;
    cnt_d = cnt_q;
    code_d = code_q;
    xor_d = xor_q;
    typeOk_d = typeOk_q;
    idx_d = idx_q;
    txXor_d = txXor_q;
    drop_d = 1'b0;
    case (state_q)
      ST_TYPE:
        if (rxTake)
        begin
          typeOk_d = (rxData == `ECF_TYPE_ESCAPE);
          xor_d = rxData;
          state_d = ST_LENL;
        end
      ST_LENL:
        if (rxTake)
        begin
          len_d = {8'h00, rxData};
          xor_d = xor_q ^ rxData;
          state_d = ST_LENH;
        end
      ST_LENH:
        if (rxTake)
        begin
          len_d = lenNow;
          xor_d = xor_q ^ rxData;
          // Foreign frames are skipped by their own length
          if (typeOk_q && lenNow >= `ECF_LEN_MIN)
            state_d = ST_CODE;
          else
          begin
            drop_d = typeOk_q;
            rem_d = lenNow;
            if (lenNow == 16'h0000)
              state_d = ST_TYPE;
            else
              state_d = ST_SKIP;
          end
        end
      ST_CODE:
        if (rxTake)
        begin
          code_d = rxData;
          xor_d = xor_q ^ rxData;
          state_d = ST_CNT;
        end
      ST_CNT:
        if (rxTake)
        begin
          cnt_d = rxData;
          xor_d = xor_q ^ rxData;
          if (len_q != lengthForCount(rxData))
          begin
            // Resync on the length field, the count is untrusted
            drop_d = 1'b1;
            rem_d = len_q - `ECF_SKIP_AFTER_COUNT;
            state_d = ST_SKIP;
          end
          else if (rxData == 8'h00)
            state_d = ST_CHK;
          else
          begin
            rem_d = {8'h00, rxData};
            state_d = ST_DATA;
          end
        end
      ST_DATA:
        if (rxTake)
        begin
          xor_d = xor_q ^ rxData;
          rem_d = rem_q - 16'h0001;
          if (rem_q == 16'h0001)
            state_d = ST_CHK;
        end
      ST_CHK:
        if (rxTake)
        begin
          state_d = ST_TYPE;
          if ((xor_q ^ rxData) != 8'h00)
            drop_d = 1'b1;
          else if (code_q == `ECF_SUB_SERIAL && cnt_q == 8'h00)
          begin
            idx_d = 4'h0;
            txXor_d = 8'h00;
            state_d = ST_RESP;
          end
        end
      ST_SKIP:
        if (rxTake)
        begin
          rem_d = rem_q - 16'h0001;
          if (rem_q == 16'h0001)
            state_d = ST_TYPE;
        end
      ST_RESP:
        if (pushReady)
        begin
          txXor_d = txXor_q ^ pushData;
          idx_d = idx_q + 4'h1;
          if (idx_q == `ECF_REPLY_LAST)
            state_d = ST_TYPE;
        end
      default:
        state_d = ST_TYPE;
    endcase
  end

  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      state_q <= ST_TYPE;
      len_q <= 16'h0000;
      rem_q <= 16'h0000;
      cnt_q <= 8'h00;
      code_q <= 8'h00;
      xor_q <= 8'h00;
      typeOk_q <= 1'b0;
      idx_q <= 4'h0;
      txXor_q <= 8'h00;
      frameDropped <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      len_q <= len_d;
      rem_q <= rem_d;
      cnt_q <= cnt_d;
      code_q <= code_d;
      xor_q <= xor_d;
      typeOk_q <= typeOk_d;
      idx_q <= idx_d;
      txXor_q <= txXor_d;
      frameDropped <= drop_d;
    end
  end

  ecf_pair_buffer replyBuffer (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .inData(pushData),
    .inValid(pushValid),
    .inReady(pushReady),
    .outData(txData),
    .outValid(txValid),
    .outReady(txReady)
  );
endmodule // ecf_framer

/* File: verilog/ecf_pair_buffer.v */
`timescale 1ns/1ps
module ecf_pair_buffer (
  input wire sys_clk,
  input wire rst_n,
  input wire [7:0] inData,
  input wire inValid,
  output wire inReady,
  output wire [7:0] outData,
  output wire outValid,
  input wire outReady
);
  reg [7:0] head_q;
  reg [7:0] tail_q;
  reg [1:0] count_q;
  wire push;
  wire pop;

  // Two entries keep full throughput while the reader takes a byte every cycle
  assign inReady = (count_q != 2'h2);
  assign outValid = (count_q != 2'h0);
  assign outData = head_q;
  assign push = inValid & inReady;
  assign pop = outValid & outReady;

  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      head_q <= 8'h00;
      tail_q <= 8'h00;
      count_q <= 2'h0;
    end
    else if (push && pop)
    begin
      if (count_q == 2'h1)
        head_q <= inData;
      else
      begin
        head_q <= tail_q;
        tail_q <= inData;
      end
    end
    else if (pop)
    begin
      head_q <= tail_q;
      count_q <= count_q - 2'h1;
    end
    else if (push)
    begin
      if (count_q == 2'h0)
        head_q <= inData;
      else
        tail_q <= inData;
      count_q <= count_q + 2'h1;
    end
  end
endmodule // ecf_pair_buffer
